// file: scm_ctrl.sv
`timescale 1ns/100ps
module scm_ctrl
#(
  parameter int TICK_CYCLES = scm_pkg::TICK_CYC
)
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [scm_pkg::AW-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [3:0]             det_pins,
  input  wire logic                   prog_button,
  output logic                        mode_lamp_a,
  output logic                        mode_lamp_b,
  output logic                        crossing_steady_lamp,
  output logic                        crossing_flash_lamp,
  output logic      [7:0]             servo1_pos,
  output logic      [7:0]             servo2_pos,
  output logic                        irq
);
  import scm_pkg::*;

  scm_state_t           state_q;
  scm_state_t           state_d;
  logic [3:0]           det_m_q;
  logic [3:0]           det_s_q;
  logic                 btn_m_q;
  logic                 btn_s_q;
  logic [3:0]           det_act;
  logic                 any_det;
  logic                 any_start;
  logic [1:0]           mode_q;
  logic                 pol_q;
  logic [7:0]           speed_q;
  logic [3:0]           sel_q;
  logic [IRQ_W-1:0]     istat_q;
  logic [IRQ_W-1:0]     imask_q;
  logic [IRQ_W-1:0]     ev;
  logic [TK_W-1:0]      tick_cnt_q;
  logic                 tick;
  logic [MS_W-1:0]      ms_cnt_q;
  logic [FL_W-1:0]      fl_cnt_q;
  logic                 flash_q;
  logic [7:0]           step_cnt_q;
  logic                 step;
  logic [1:0]           boot_q;
  logic                 wr;
  logic                 setup;
  logic                 hit;
  logic                 rd_srv_q;
  logic                 rd_vld_q;
  logic [2:0]           rd_idx;
  logic [7:0]           rd_data;
  logic [1:0]           pos_sel [2];
  logic [7:0]           tgt_q [2];
  logic [7:0]           srv_q [2];
  logic                 init_end;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      det_m_q <= 4'h0;
      det_s_q <= 4'h0;
      btn_m_q <= 1'b0;
      btn_s_q <= 1'b0;
    end
    else
    begin
      det_m_q <= det_pins;
      det_s_q <= det_m_q;
      btn_m_q <= prog_button;
      btn_s_q <= btn_m_q;
    end
  end

  // Polarity applied to the synchronised detectors
  assign det_act   = pol_q ? det_s_q : ~det_s_q;
  assign any_det   = |det_act;
  assign any_start = det_act[DET_S1] | det_act[DET_S2];

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick, flasher and servo step enables
  assign tick = (tick_cnt_q == TK_W'(TICK_CYCLES - 1));
  assign step = tick && (step_cnt_q == speed_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_cnt_q <= '0;
      flash_q  <= 1'b0;
    end
    else if (tick)
    begin
      if (fl_cnt_q == FL_W'(FLASH_MS - 1))
      begin
        fl_cnt_q <= '0;
        flash_q  <= ~flash_q;
      end
      else
        fl_cnt_q <= fl_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      step_cnt_q <= '0;
    else if (step)
      step_cnt_q <= '0;
    else if (tick)
      step_cnt_q <= step_cnt_q + 1'b1;
  end

  // Time spent in the present state, in milliseconds
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ms_cnt_q <= '0;
    else if (state_d != state_q)
      ms_cnt_q <= '0;
    else if (tick)
      ms_cnt_q <= ms_cnt_q + 1'b1;
  end

  // Strap wait after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      boot_q <= '0;
    else if (state_q == ST_BOOT)
      boot_q <= boot_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB access decode; zero wait states
  assign pready = 1'b1;
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite;
  assign hit    = (paddr[1:0] == 2'h0) && (paddr <= A_SERVO);
  assign pslverr = psel && penable && !hit;

  ////////////////////////////////////////////////////////////////////////////
  // Operating state
  assign init_end = tick && (ms_cnt_q == MS_W'(INIT_MS - 1));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_BOOT:
        if (boot_q == 2'(BOOT_CYC))
          state_d = btn_s_q ? ST_PMODE : ST_INIT;
      ST_PMODE:
        if (wr && paddr == A_PROG)
          state_d = ST_PPOL;
      ST_PPOL:
        if (wr && paddr == A_PROG)
          state_d = ST_INIT;
      ST_INIT:
        if (init_end)
        begin
          if (mode_q == MODE_1 && any_det)
            state_d = ST_ACTIVE;
          else
            state_d = ST_IDLE;
        end
      ST_IDLE:
        if ((mode_q == MODE_1 || mode_q == MODE_2) && any_start)
          state_d = ST_ARM;
      ST_ARM:
        if (tick && ms_cnt_q == MS_W'(START_MS - 1))
          state_d = ST_ACTIVE;
      ST_ACTIVE:
        if (!any_det)
          state_d = ST_IDLE;
      default:
        state_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_BOOT;
    else
      state_q <= state_d;
  end

  // Programmed mode and polarity, factory values at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= MODE_1;
      pol_q  <= POL_POS;
    end
    else if (wr && paddr == A_PROG)
    begin
      if (state_q == ST_PMODE)
        mode_q <= pwdata[1:0];
      else if (state_q == ST_PPOL)
        pol_q <= pwdata[0];
    end
  end

  // Software controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      speed_q <= SPEED_RST;
      sel_q   <= '0;
      imask_q <= '0;
    end
    else if (wr)
    begin
      if (paddr == A_CTRL)
        speed_q <= pwdata[7:0];
      if (paddr == A_SEL)
        sel_q <= pwdata[3:0];
      if (paddr == A_IMASK)
        imask_q <= pwdata[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events; a new event wins over a write-one clear
  always_comb
  begin
    ev = '0;
    ev[IRQ_INIT]   = (state_q == ST_INIT) && (state_d != ST_INIT);
    ev[IRQ_XSTART] = (state_q != ST_ACTIVE) && (state_d == ST_ACTIVE);
    ev[IRQ_XEND]   = (state_q == ST_ACTIVE) && (state_d != ST_ACTIVE);
    ev[IRQ_PROG]   = (state_q == ST_PPOL) && (state_d != ST_PPOL);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      istat_q <= '0;
    else if (wr && paddr == A_ISTAT)
      istat_q <= (istat_q & ~pwdata[IRQ_W-1:0]) | ev;
    else
      istat_q <= istat_q | ev;
  end

  assign irq = |(istat_q & imask_q);

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (setup)
    begin
      prdata <= '0;
      case (paddr)
        A_CTRL:  prdata[7:0] <= speed_q;
        A_STAT:  prdata[STAT_PH:0] <= {state_q == ST_PPOL, state_q,
                                       pol_q, mode_q};
        A_SEL:   prdata[3:0] <= sel_q;
        A_ISTAT: prdata[IRQ_W-1:0] <= istat_q;
        A_IMASK: prdata[IRQ_W-1:0] <= imask_q;
        A_SERVO: prdata[15:0] <= {srv_q[1], srv_q[0]};
        default: prdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Position table, read alternately for each servo
  scm_pos_mem u_mem
  (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (wr && paddr == A_POS),
    .wr_idx  (pwdata[POS_IDX_LSB +: 3]),
    .wr_data (pwdata[7:0]),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  assign rd_idx = {~rd_srv_q, pos_sel[~rd_srv_q]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_srv_q <= 1'b0;
      rd_vld_q <= 1'b0;
    end
    else
    begin
      rd_srv_q <= ~rd_srv_q;
      rd_vld_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-servo position choice and slewing
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++)
    begin : g_srv
      always_comb
      begin
        pos_sel[gs] = POS_HOME;
        if (state_q == ST_ACTIVE)
          pos_sel[gs] = POS_DOWN;
        else if (state_q == ST_IDLE && mode_q == MODE_3)
          pos_sel[gs] = det_act[gs ? DET_S2 : DET_S1] ? POS_DOWN : POS_HOME;
        else if (state_q == ST_IDLE && mode_q == MODE_4)
          pos_sel[gs] = sel_q[gs*2 +: 2];
      end

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          tgt_q[gs] <= SERVO_RST;
        else if (rd_vld_q && rd_srv_q == 1'(gs))
          tgt_q[gs] <= rd_data;
      end

      // One step toward the target per speed period
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          srv_q[gs] <= SERVO_RST;
        else if (step && srv_q[gs] < tgt_q[gs])
          srv_q[gs] <= srv_q[gs] + 1'b1;
        else if (step && srv_q[gs] > tgt_q[gs])
          srv_q[gs] <= srv_q[gs] - 1'b1;
      end
    end
  endgenerate

  assign servo1_pos = srv_q[0];
  assign servo2_pos = srv_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Lamps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_lamp_a          <= 1'b0;
      mode_lamp_b          <= 1'b0;
      crossing_steady_lamp <= 1'b0;
      crossing_flash_lamp  <= 1'b0;
    end
    else
    begin
      crossing_steady_lamp <= (state_q == ST_ACTIVE);
      crossing_flash_lamp  <= (state_q == ST_ACTIVE) && flash_q;
      if (state_q == ST_PMODE || state_q == ST_PPOL)
      begin
        mode_lamp_a <= flash_q;
        mode_lamp_b <= flash_q;
      end
      else if (state_q == ST_ACTIVE)
      begin
        mode_lamp_a <= flash_q;
        mode_lamp_b <= 1'b1;
      end
      else
      begin
        mode_lamp_a <= (mode_q == MODE_1) || (mode_q == MODE_3);
        mode_lamp_b <= (mode_q == MODE_1) || (mode_q == MODE_2);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lamp_mode;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_IDLE |=> mode_lamp_a == ($past(mode_q) == MODE_1 ||
      $past(mode_q) == MODE_3) && mode_lamp_b ==
      ($past(mode_q) == MODE_1 || $past(mode_q) == MODE_2);
  endproperty
  a_lamp_mode: assert property (p_lamp_mode)
    else $error("mode lamps do not match mode");

  property p_factory;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_BOOT |-> mode_q == MODE_1 && pol_q == POL_POS;
  endproperty
  a_factory: assert property (p_factory)
    else $error("factory mode or polarity wrong");

  property p_init_len;
    @(posedge pclk) disable iff (!presetn)
    $past(state_q) == ST_INIT && state_q != ST_INIT |->
      $past(ms_cnt_q) == MS_W'(INIT_MS - 1) && $past(tick);
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("start-up phase length wrong");

  property p_prog_mode;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_PMODE && wr && paddr == A_PROG |=>
      state_q == ST_PPOL && mode_q == $past(pwdata[1:0]);
  endproperty
  a_prog_mode: assert property (p_prog_mode)
    else $error("mode phase not taken");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
    $stable(pol_q) && $past(presetn, 2) |->
      det_act == (pol_q ? $past(det_pins, 2) : ~$past(det_pins, 2));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("detector polarity wrong");

  property p_boot_event;
    @(posedge pclk) disable iff (!presetn)
    init_end && state_q == ST_INIT && mode_q == MODE_1 && any_det |=>
      state_q == ST_ACTIVE ##1 mode_lamp_b && crossing_steady_lamp;
  endproperty
  a_boot_event: assert property (p_boot_event)
    else $error("no crossing event at power-up");

  property p_prog_lamps;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_PMODE |=> mode_lamp_a == $past(flash_q) &&
      mode_lamp_b == $past(flash_q);
  endproperty
  a_prog_lamps: assert property (p_prog_lamps)
    else $error("stored mode shown in programming");

  property p_arm;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_IDLE && (mode_q == MODE_1 || mode_q == MODE_2) &&
      any_start |=> state_q == ST_ARM;
  endproperty
  a_arm: assert property (p_arm)
    else $error("start detector ignored");

  property p_delay;
    @(posedge pclk) disable iff (!presetn)
    $past(state_q) == ST_ARM && state_q != ST_ARM |->
      state_q == ST_ACTIVE && $past(ms_cnt_q) == MS_W'(START_MS - 1);
  endproperty
  a_delay: assert property (p_delay)
    else $error("gate delay wrong");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
    state_q == ST_ACTIVE && !any_det |=>
      state_q == ST_IDLE ##1 !crossing_flash_lamp && !crossing_steady_lamp;
  endproperty
  a_release: assert property (p_release)
    else $error("crossing did not end");

  property p_slew;
    @(posedge pclk) disable iff (!presetn)
    srv_q[0] != $past(srv_q[0]) |-> $past(step);
  endproperty
  a_slew: assert property (p_slew)
    else $error("servo moved off a step");

endmodule

// file: scm_ctrl_bench.sv
`timescale 1ns/100ps
module scm_ctrl_bench;
  import scm_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  det_pins;
  logic [3:0]  occupied;
  logic        neg_pol;
  logic        prog_button;
  logic        lamp_a;
  logic        lamp_b;
  logic        steady;
  logic        flash;
  logic [7:0]  servo1;
  logic [7:0]  servo2;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          samples_checked;

  ////////////////////////////////////////////////////////////////////////////
  // Design with a short tick, and the sensor cable
  scm_ctrl #(.TICK_CYCLES(1)) dut
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .det_pins             (det_pins),
    .prog_button          (prog_button),
    .mode_lamp_a          (lamp_a),
    .mode_lamp_b          (lamp_b),
    .crossing_steady_lamp (steady),
    .crossing_flash_lamp  (flash),
    .servo1_pos           (servo1),
    .servo2_pos           (servo2),
    .irq                  (irq)
  );
  scm_sensors sensors
  (
    .occupied (occupied),
    .neg_pol  (neg_pol),
    .det_pins (det_pins)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Compares and bus cycles
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error land in rd and er
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready ends the access; the watchdog covers a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll the state field until it matches or the polls run out
  task automatic wait_state(input logic [6:0] st, input int polls);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end
    while (rd[9:3] !== st && n < polls);
    chk_reg(32'(rd[9:3]), 32'(st));
  endtask
  task automatic wait_servo(input logic [7:0] e1, input logic [7:0] e2);
    int n;
    n = 0;
    while ((servo1 !== e1 || servo2 !== e2) && n < 4000)
    begin
      @(posedge pclk);
      n++;
    end
    chk_pin(servo1, e1);
    chk_pin(servo2, e2);
  endtask
  // Lamp must change within one full flash period plus margin
  task automatic wait_toggle(input bit pick);
    logic v;
    int   n;
    v = pick ? lamp_a : flash;
    n = 0;
    while ((pick ? lamp_a : flash) === v && n < 1100)
    begin
      @(posedge pclk);
      n++;
    end
    chk_pin({7'h0, n < 1100}, 8'h01);
  endtask
  task automatic do_reset(input logic btn, input logic [3:0] occ);
    @(posedge pclk);
    presetn <= 1'b0;
    prog_button <= btn;
    occupied <= occ;
    repeat (8) @(posedge pclk);
    chk_pin(servo1, SERVO_RST);
    chk_pin({2'h0, irq, pready, lamp_a, lamp_b, steady, flash}, 8'h10);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    prog_button <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_defaults;
    apb(1'b0, A_STAT, 32'h0);
    chk_reg(rd & 32'h7, 32'h4);
    apb(1'b0, A_CTRL, 32'h0);
    chk_reg(rd, 32'(SPEED_RST));
    apb(1'b0, 8'h20, 32'h0);
    chk_reg({31'h0, er}, 32'h1);
    wait_state(ST_IDLE, 9000);
    wait_servo(8'h20, 8'h20);
    chk_pin({6'h0, lamp_a, lamp_b}, 8'h03);
    apb(1'b1, A_PROG, 32'h3);
    apb(1'b0, A_STAT, 32'h0);
    chk_reg(rd & 32'h3, 32'h0);
  endtask
  task automatic t_irq;
    apb(1'b0, A_ISTAT, 32'h0);
    chk_reg(rd & 32'h1, 32'h1);
    @(negedge pclk);
    chk_pin({7'h0, irq}, 8'h00);
    apb(1'b1, A_IMASK, 32'h1);
    @(negedge pclk);
    chk_pin({7'h0, irq}, 8'h01);
    apb(1'b1, A_ISTAT, 32'h1);
    @(negedge pclk);
    chk_pin({7'h0, irq}, 8'h00);
    apb(1'b1, A_IMASK, 32'h0);
  endtask
  task automatic t_crossing;
    occupied <= 4'h1;
    wait_state(ST_ARM, 20);
    repeat (2500) @(posedge pclk);
    wait_state(ST_ARM, 1);
    occupied <= 4'h2;
    wait_state(ST_ACTIVE, 700);
    @(negedge pclk);
    chk_pin({6'h0, lamp_b, steady}, 8'h03);
    wait_toggle(1'b0);
    wait_servo(8'hE0, 8'hE0);
    wait_state(ST_ACTIVE, 1);
    occupied <= 4'h0;
    wait_state(ST_IDLE, 20);
    @(negedge pclk);
    chk_pin({6'h0, steady, flash}, 8'h00);
    wait_servo(8'h20, 8'h20);
    apb(1'b0, A_ISTAT, 32'h0);
    chk_reg(rd & 32'h6, 32'h6);
  endtask
  task automatic t_program;
    do_reset(1'b1, 4'h0);
    wait_state(ST_PMODE, 10);
    wait_toggle(1'b1);
    apb(1'b1, A_PROG, 32'(MODE_4));
    apb(1'b0, A_STAT, 32'h0);
    chk_reg(rd & 32'h7F8, {21'h0, 1'b1, ST_PPOL, 3'h0});
    neg_pol <= 1'b1;
    apb(1'b1, A_PROG, 32'h0);
    wait_state(ST_IDLE, 9000);
    chk_reg(rd & 32'h7, 32'h3);
    chk_pin({6'h0, lamp_a, lamp_b}, 8'h00);
    apb(1'b0, A_ISTAT, 32'h0);
    chk_reg(rd & 32'h8, 32'h8);
    apb(1'b1, A_POS, 32'h0755);
    apb(1'b1, A_SEL, 32'hD);
    wait_servo(8'hE0, 8'h55);
    apb(1'b0, A_SERVO, 32'h0);
    chk_reg(rd, 32'h55E0);
  endtask
  task automatic t_turnout;
    neg_pol <= 1'b0;
    do_reset(1'b1, 4'h0);
    wait_state(ST_PMODE, 10);
    apb(1'b1, A_PROG, 32'(MODE_3));
    apb(1'b1, A_PROG, 32'h1);
    wait_state(ST_IDLE, 9000);
    chk_reg(rd & 32'h7, 32'h6);
    chk_pin({6'h0, lamp_a, lamp_b}, 8'h02);
    occupied <= 4'h8;
    wait_servo(8'h20, 8'hE0);
    wait_state(ST_IDLE, 1);
    occupied <= 4'h0;
    wait_servo(8'h20, 8'h20);
  endtask
  task automatic t_power_active;
    neg_pol <= 1'b0;
    do_reset(1'b0, 4'h1);
    wait_state(ST_ACTIVE, 9000);
    chk_pin({6'h0, lamp_b, steady}, 8'h03);
    wait_toggle(1'b1);
    wait_servo(8'hE0, 8'hE0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, clock, watchdog and main sequence
  task automatic give_verdict;
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (80000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    occupied = 4'h0;
    neg_pol = 1'b0;
    prog_button = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    do_reset(1'b0, 4'h0);
    t_defaults();
    t_irq();
    t_crossing();
    t_program();
    t_turnout();
    t_power_active();
    give_verdict();
  end
endmodule

// file: scm_pkg.sv
package scm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_NS    = 25;          // 40 MHz system clock
  localparam int TICK_NS   = 1000000;     // Base tick, one millisecond
  localparam int TICK_CYC  = TICK_NS / CLK_NS;
  localparam int INIT_MS   = 12000;       // Servo start-up, 10 to 15 s
  localparam int START_MS  = 3000;        // Delay before gates move
  localparam int FLASH_MS  = 500;         // Half period of lamp flashing
  localparam int BOOT_CYC  = 3;           // Wait for strap synchroniser
  localparam int MS_W      = 14;
  localparam int FL_W      = 9;
  localparam int TK_W      = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int AW = 8;
  localparam logic [AW-1:0] A_CTRL  = 8'h00;  // Servo step speed
  localparam logic [AW-1:0] A_PROG  = 8'h04;  // Programming data
  localparam logic [AW-1:0] A_STAT  = 8'h08;  // Mode, polarity, state
  localparam logic [AW-1:0] A_POS   = 8'h0C;  // Position table write
  localparam logic [AW-1:0] A_SEL   = 8'h10;  // Four-position select
  localparam logic [AW-1:0] A_ISTAT = 8'h14;  // Sticky events, W1C
  localparam logic [AW-1:0] A_IMASK = 8'h18;  // Event mask
  localparam logic [AW-1:0] A_SERVO = 8'h1C;  // Present servo positions

  // Fields
  localparam int POS_IDX_LSB = 8;
  localparam int STAT_POL    = 2;
  localparam int STAT_ST_LSB = 3;
  localparam int STAT_PH     = 10;
  localparam logic [7:0] SPEED_RST = 8'h04;

  ////////////////////////////////////////////////////////////////////////////
  // Modes, stored as number minus one
  localparam logic [1:0] MODE_1 = 2'h0;  // Crossing, supplied sensors
  localparam logic [1:0] MODE_2 = 2'h1;  // Crossing, owner detectors
  localparam logic [1:0] MODE_3 = 2'h2;  // Two turnouts
  localparam logic [1:0] MODE_4 = 2'h3;  // Four stored positions
  localparam logic       POL_POS = 1'b1;

  // Detector order on the input cable
  localparam int DET_S1 = 0;
  localparam int DET_H1 = 1;
  localparam int DET_H2 = 2;
  localparam int DET_S2 = 3;

  // Position table: index {servo, position-1}
  localparam logic [1:0] POS_HOME = 2'h0;
  localparam logic [1:0] POS_DOWN = 2'h1;
  localparam logic [63:0] POS_DEF = 64'hA0A0_E020_A0A0_E020;
  localparam logic [7:0] SERVO_RST = 8'h80;

  // Event bits
  localparam int IRQ_W      = 4;
  localparam int IRQ_INIT   = 0;
  localparam int IRQ_XSTART = 1;
  localparam int IRQ_XEND   = 2;
  localparam int IRQ_PROG   = 3;

  typedef enum logic [6:0] {
    ST_BOOT   = 7'h01,
    ST_PMODE  = 7'h02,
    ST_PPOL   = 7'h04,
    ST_INIT   = 7'h08,
    ST_IDLE   = 7'h10,
    ST_ARM    = 7'h20,
    ST_ACTIVE = 7'h40
  } scm_state_t;

endpackage

// file: scm_pos_mem.sv
`timescale 1ns/100ps
module scm_pos_mem
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [2:0] rd_idx,
  output logic      [7:0] rd_data
);
  import scm_pkg::*;

  logic [7:0] mem_q [8];

  ////////////////////////////////////////////////////////////////////////////
  // One stored position per entry, loaded with defaults at reset
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_ent
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mem_q[gi] <= POS_DEF[gi*8 +: 8];
        else if (wr_en && wr_idx == 3'(gi))
          mem_q[gi] <= wr_data;
      end
    end
  endgenerate

  // Registered read port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_data <= SERVO_RST;
    else
      rd_data <= mem_q[rd_idx];
  end

endmodule

// file: scm_sensors.sv
`timescale 1ns/100ps
// Track sensor cable: occupancy in, pin levels out
module scm_sensors
(
  input  wire logic [3:0] occupied,
  input  wire logic       neg_pol,
  output logic      [3:0] det_pins
);
  // Occupied sensor shows its active level, order s1 h1 h2 s2
  assign det_pins = occupied ^ {4{neg_pol}};
endmodule
